/* File: rtl/bpna_defines.vh */
// Constants of the bulk notify and bulk object access command block
`ifndef BPNA_DEFINES_VH
`define BPNA_DEFINES_VH
// Frame fields
`define BPNA_START_OCTET 8'h02
`define BPNA_FRAME_TYPE 16'h0003
`define BPNA_CMD_NOTIFY 8'h22
`define BPNA_CMD_ACCESS 8'h23
`define BPNA_RSP_NOTIFY 8'ha2
`define BPNA_RSP_ACCESS 8'ha3
`define BPNA_NOTIFY_LEN 16'h0002
`define BPNA_RESULT_LEN 16'h0002
// Notify classes and access operations
`define BPNA_CLASS_GET 8'h00
`define BPNA_CLASS_SET 8'h01
`define BPNA_CLASS_MAX 8'h03
`define BPNA_OP_READ 8'h00
`define BPNA_OP_WRITE 8'h01
// Result codes
`define BPNA_RES_OK 16'h0000
`define BPNA_RES_OK_NETDOWN 16'h0001
`define BPNA_RES_REJ 16'h0011
`define BPNA_RES_REJ_OTHER 16'h0012
`define BPNA_RES_UNCONF 16'h0101
`define BPNA_RES_STANDBY 16'h0103
`define BPNA_RES_CONSTR 16'h0104
`define BPNA_RES_ERRSTOP 16'h0105
`define BPNA_RES_ERR 16'hffff
// Adapter state encodings
`define BPNA_ST_OPER 3'h0
`define BPNA_ST_UNCONF 3'h1
`define BPNA_ST_STANDBY 3'h3
`define BPNA_ST_CONSTR 3'h4
`define BPNA_ST_ERRSTOP 3'h5
// Octet positions within a request frame
`define BPNA_POS_START 10'h000
`define BPNA_POS_TYPE_HI 10'h001
`define BPNA_POS_TYPE_LO 10'h002
`define BPNA_POS_CMD 10'h003
`define BPNA_POS_SEQ 10'h004
`define BPNA_POS_OP 10'h007
`define BPNA_POS_OBJ_END 10'h00a
`define BPNA_POS_VALS 10'h00b
// Octet positions within a response frame
`define BPNA_TPOS_RES_LO 10'h008
`define BPNA_TPOS_VALS 10'h009
// Register offsets, fields and reset values
`define BPNA_REG_CTRL 4'h0
`define BPNA_REG_OBJ 4'h4
`define BPNA_REG_STAT 4'h8
`define BPNA_CTRL_EN_BIT 0
`define BPNA_CTRL_RESET 1'b1
`define BPNA_OBJ_RESET 24'h000000
`endif

/* File: rtl/bpna_fifo.v */
// Octet FIFO between the response builder and the link transmitter
`timescale 1ns/1ps
module bpna_fifo #(
   parameter W = 9,
   parameter DEPTH = 16
) (
   input wire mclk,
   input wire rstn,
   input wire [W-1:0] inData,
   input wire inValid,
   output wire inReady,
   output wire [W-1:0] outData,
   output wire outValid,
   input wire outReady
);
   localparam AW = $clog2(DEPTH);
   reg [W-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr;
   reg [AW-1:0] rdPtr;
   reg [AW:0] fill;
   wire push;
   wire pop;

   assign inReady = (fill != DEPTH[AW:0]);
   assign outValid = (fill != {(AW+1){1'b0}});
   assign outData = mem[rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always @(posedge mclk)
   begin
      if (!rstn)
      begin
         wrPtr <= {AW{1'b0}};
         rdPtr <= {AW{1'b0}};
         fill <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            mem[wrPtr] <= inData;
            wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
         end
         if (pop)
            rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
         if (push && !pop)
            fill <= fill + 1'b1;
         else if (pop && !push)
            fill <= fill - 1'b1;
      end
   end
endmodule

/* File: rtl/bpna_prop_store.v */
// Getter and setter property values with written-from-outside marks
`timescale 1ns/1ps
module bpna_prop_store #(
   parameter N = 8,
   parameter IW = 3
) (
   input wire mclk,
   input wire rstn,
   input wire getWr,
   input wire setWr,
   input wire [IW-1:0] wrIdx,
   input wire [7:0] wrData,
   input wire extWr,
   input wire [IW-1:0] extIdx,
   input wire [7:0] extData,
   input wire clrFlags,
   input wire [IW-1:0] rdIdx,
   output wire [7:0] setVal,
   output wire [7:0] getVal,
   output reg [N-1:0] flags
);
   reg [7:0] getMem [0:N-1];
   reg [7:0] setMem [0:N-1];
   integer i;

   assign setVal = setMem[rdIdx];
   assign getVal = getMem[extIdx];

   always @(posedge mclk)
   begin
      if (!rstn)
      begin
         flags <= {N{1'b0}};
         for (i = 0; i < N; i = i + 1)
         begin
            getMem[i] <= 8'h00;
            setMem[i] <= 8'h00;
         end
      end
      else
      begin
         if (getWr)
            getMem[wrIdx] <= wrData;
         if (setWr)
            setMem[wrIdx] <= wrData;
         if (extWr)
            setMem[extIdx] <= extData;
         // Outside write in the clearing cycle keeps its mark
         for (i = 0; i < N; i = i + 1)
            flags[i] <= (extWr && extIdx == i[IW-1:0]) ? 1'b1 : (flags[i] && !clrFlags);
      end
   end
endmodule

/* File: rtl/bpna_bulk_access.v */
// Bulk notify and bulk object access command handler of the network adapter
// Overview of operation
// [R01] Notify class 0..3 picks property class
// [R02] Notify values arrive in ascending code order
// [R03] Announce count then that many codes follow
// [R04] Notify response: start, type, 0xA2, length 2
// [R05] Notify result accepted, net down, other, error
// [R06] State mismatch results 0101, 0103, 0104, 0105
// [R07] Access request uses type 3, command 0x23
// [R08] Access code 0 reads, 1 writes
// [R09] Write request carries getter values in order
// [R10] Every access request gets a matching response; here none if disabled or cut before the operation octet
// [R11] Access response: 0xA3, echoed sequence, full length
// [R12] Access result accepted, accepted net down, rejected, error
// [R13] Setter values only for accepted read requests
// [R14] Count and codes of outside-written properties follow
// [R15] Adapter only answers notify and access requests
// [R16] Notify request uses type 3, command 0x22
// [R17] Notify answered and flagged codes announced
// [R18] Getter or setter values overwrite stored copies
// [R19] Reserved access codes answer other error
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "bpna_defines.vh"
module bpna_bulk_access #(
   parameter N = 8,
   parameter PROP_BASE = 8'h80,
   parameter FIFO_DEPTH = 16
) (
   input wire mclk,
   input wire rstn,
   input wire [7:0] rxData,
   input wire rxValid,
   input wire rxLast,
   output wire rxReady,
   output wire [7:0] txData,
   output wire txValid,
   output wire txLast,
   input wire txReady,
   input wire netUp,
   input wire [2:0] adapterState,
   input wire extWr,
   input wire [$clog2(N)-1:0] extIdx,
   input wire [7:0] extData,
   output reg [7:0] extGetVal,
   output reg announceValid,
   output reg [7:0] announceCode,
   input wire [3:0] regAddr,
   input wire [31:0] regWdata,
   input wire regWr,
   input wire regRd,
   output reg [31:0] regRdata
);
   localparam IW = $clog2(N);
   localparam S_RX = 2'd0;
   localparam S_DROP = 2'd1;
   localparam S_TX = 2'd2;
   localparam [9:0] NP = N;
   localparam [9:0] P_CNT = `BPNA_POS_VALS + NP;
   localparam [9:0] T_CNT = `BPNA_TPOS_VALS + NP;
   localparam [15:0] FT = `BPNA_FRAME_TYPE;

   reg [1:0] state;
   reg [9:0] pos;
   reg isNotify;
   reg [7:0] seq;
   reg [7:0] op;
   reg [23:0] objCode;
   reg [15:0] result;
   reg [7:0] annCount;
   reg withData;
   reg [N-1:0] flagSnap;
   reg [7:0] codeCnt;
   reg [9:0] txPos;
   reg [7:0] k;
   reg ctrlEn;
   reg [23:0] objReg;
   reg [15:0] served;
   reg [7:0] nextTxByte;
   reg nextTxLast;
   wire [7:0] setVal;
   wire [7:0] getVal;
   wire [N-1:0] flags;
   wire fifoInReady;
   wire rxTake;
   wire accepted;
   wire inVals;
   wire getWr;
   wire setWr;
   wire clrFlags;
   wire objHit;
   wire readDone;
   wire txPush;
   wire [9:0] valOff;
   wire [9:0] txOff;
   wire [15:0] rspLen;

   function [15:0] stateResult;
      input [2:0] st;
      begin
         case (st)
            `BPNA_ST_UNCONF: stateResult = `BPNA_RES_UNCONF;
            `BPNA_ST_STANDBY: stateResult = `BPNA_RES_STANDBY;
            `BPNA_ST_CONSTR: stateResult = `BPNA_RES_CONSTR;
            `BPNA_ST_ERRSTOP: stateResult = `BPNA_RES_ERRSTOP;
            default: stateResult = `BPNA_RES_ERR;
         endcase
      end
   endfunction

   function [7:0] popCount;
      input [N-1:0] f;
      integer i;
      begin
         popCount = 8'h00;
         for (i = 0; i < N; i = i + 1)
            popCount = popCount + {7'h00, f[i]};
      end
   endfunction

   // Index of the set mark with rank kk
   function [IW-1:0] nthSet;
      input [N-1:0] f;
      input [7:0] kk;
      integer i;
      reg [7:0] seen;
      begin
         seen = 8'h00;
         nthSet = {IW{1'b0}};
         for (i = 0; i < N; i = i + 1)
         begin
            if (f[i])
            begin
               if (seen == kk)
                  nthSet = i[IW-1:0];
               seen = seen + 8'h01;
            end
         end
      end
   endfunction

   assign rxReady = (state != S_TX);
   assign rxTake = rxValid && rxReady;
   assign accepted = (result == `BPNA_RES_OK) || (result == `BPNA_RES_OK_NETDOWN);
   assign valOff = pos - `BPNA_POS_VALS;
   assign inVals = (state == S_RX) && rxTake && (pos >= `BPNA_POS_VALS) && (pos < P_CNT);
   // Values stored only once the request is known good
   assign getWr = inVals && accepted &&
      ((isNotify && op == `BPNA_CLASS_GET) || (!isNotify && op == `BPNA_OP_WRITE)); // [R18] [R09]
   assign setWr = inVals && accepted && isNotify && (op == `BPNA_CLASS_SET); // [R18]
   // Marks restart after every read that returns values
   assign objHit = ({objCode[15:0], rxData} == objReg);
   // Object match counts already on its own last octet
   assign readDone = rxTake && rxLast && !isNotify && accepted && (op == `BPNA_OP_READ) &&
      (pos > `BPNA_POS_OBJ_END || (pos == `BPNA_POS_OBJ_END && objHit)); // [R13]
   assign clrFlags = (state == S_RX) && readDone; // [R14]

   bpna_prop_store #(
      .N(N),
      .IW(IW)
   ) uStore (
      .mclk(mclk),
      .rstn(rstn),
      .getWr(getWr),
      .setWr(setWr),
      .wrIdx(valOff[IW-1:0]),
      .wrData(rxData),
      .extWr(extWr),
      .extIdx(extIdx),
      .extData(extData),
      .clrFlags(clrFlags),
      .rdIdx(txOff[IW-1:0]),
      .setVal(setVal),
      .getVal(getVal),
      .flags(flags)
   );

   // Receive side: positional parse of one request frame
   always @(posedge mclk)
   begin
      if (!rstn)
      begin
         state <= S_RX;
         pos <= 10'h000;
         isNotify <= 1'b0;
         seq <= 8'h00;
         op <= 8'h00;
         objCode <= 24'h000000;
         result <= `BPNA_RES_ERR;
         annCount <= 8'h00;
         withData <= 1'b0;
         flagSnap <= {N{1'b0}};
         codeCnt <= 8'h00;
         announceValid <= 1'b0;
         announceCode <= 8'h00;
         txPos <= 10'h000;
         k <= 8'h00;
         served <= 16'h0000;
      end
      else
      begin
         announceValid <= 1'b0;
         case (state)
            S_RX:
            begin
               if (rxTake)
               begin
                  pos <= pos + 10'h001;
                  if (pos == `BPNA_POS_START && (rxData != `BPNA_START_OCTET || !ctrlEn))
                     state <= S_DROP;
                  else if (pos == `BPNA_POS_TYPE_HI && rxData != FT[15:8])
                     state <= S_DROP; // [R07] [R16]
                  else if (pos == `BPNA_POS_TYPE_LO && rxData != FT[7:0])
                     state <= S_DROP; // [R07] [R16]
                  else if (pos == `BPNA_POS_CMD)
                  begin
                     // Only requests are taken; response codes are never accepted here
                     if (rxData == `BPNA_CMD_NOTIFY)
                        isNotify <= 1'b1; // [R16]
                     else if (rxData == `BPNA_CMD_ACCESS)
                        isNotify <= 1'b0; // [R07] [R15]
                     else
                        state <= S_DROP;
                  end
                  else if (pos == `BPNA_POS_SEQ)
                     seq <= rxData;
                  else if (pos == `BPNA_POS_OP)
                  begin
                     op <= rxData;
                     if (adapterState != `BPNA_ST_OPER)
                        result <= stateResult(adapterState); // [R06]
                     else if (isNotify && rxData > `BPNA_CLASS_MAX)
                        result <= `BPNA_RES_ERR; // [R01] [R19]
                     else if (!isNotify && rxData > `BPNA_OP_WRITE)
                        result <= `BPNA_RES_ERR; // [R08] [R19]
                     else if (isNotify)
                        result <= netUp ? `BPNA_RES_OK : `BPNA_RES_REJ; // [R05]
                     else
                        result <= netUp ? `BPNA_RES_OK : `BPNA_RES_OK_NETDOWN; // [R12]
                  end
                  else if (pos > `BPNA_POS_OP && pos <= `BPNA_POS_OBJ_END)
                  begin
                     objCode <= {objCode[15:0], rxData};
                     if (pos == `BPNA_POS_OBJ_END && accepted && !objHit)
                        result <= isNotify ? `BPNA_RES_REJ_OTHER : `BPNA_RES_REJ; // [R05] [R12]
                  end
                  else if (isNotify && pos == P_CNT)
                  begin
                     annCount <= rxData; // [R03]
                     if (rxData > NP[7:0] && accepted)
                        result <= `BPNA_RES_REJ_OTHER; // [R05]
                  end
                  else if (isNotify && pos > P_CNT && accepted &&
                     (pos - P_CNT) <= {2'b00, annCount})
                  begin
                     announceValid <= 1'b1; // [R17] [R03]
                     announceCode <= rxData;
                  end
                  if (rxLast)
                  begin
                     pos <= 10'h000;
                     if (pos >= `BPNA_POS_OP && state == S_RX)
                     begin
                        // Frames short of the operation octet get no answer
                        state <= S_TX; // [R10] [R17]
                        txPos <= 10'h000;
                        k <= 8'h00;
                        withData <= 1'b0;
                        if (readDone)
                        begin
                           withData <= 1'b1; // [R13]
                           flagSnap <= flags; // [R14]
                           codeCnt <= popCount(flags); // [R14]
                        end
                     end
                     else
                        state <= S_RX;
                  end
               end
            end
            S_DROP:
            begin
               if (rxTake && rxLast)
               begin
                  state <= S_RX;
                  pos <= 10'h000;
               end
            end
            S_TX:
            begin
               if (txPush)
               begin
                  txPos <= txPos + 10'h001;
                  if (txPos > T_CNT)
                     k <= k + 8'h01;
                  if (nextTxLast)
                  begin
                     state <= S_RX;
                     served <= served + 16'h0001;
                  end
               end
            end
            default:
               state <= S_RX;
         endcase
      end
   end

   // Transmit side: response octets into the FIFO
   assign txOff = txPos - `BPNA_TPOS_VALS;
   assign rspLen = isNotify ? `BPNA_NOTIFY_LEN : withData ?
      `BPNA_RESULT_LEN + {6'h00, NP} + 16'h0001 + {8'h00, codeCnt} : `BPNA_RESULT_LEN; // [R04] [R11]
   assign txPush = (state == S_TX) && fifoInReady;

   always @*
   begin
      nextTxByte = 8'h00;
      nextTxLast = 1'b0;
      case (txPos)
         10'h000: nextTxByte = `BPNA_START_OCTET; // [R04] [R11]
         10'h001: nextTxByte = FT[15:8];
         10'h002: nextTxByte = FT[7:0];
         10'h003: nextTxByte = isNotify ? `BPNA_RSP_NOTIFY : `BPNA_RSP_ACCESS; // [R04] [R11]
         10'h004: nextTxByte = seq; // [R04] [R11]
         10'h005: nextTxByte = rspLen[15:8];
         10'h006: nextTxByte = rspLen[7:0];
         10'h007: nextTxByte = result[15:8]; // [R05] [R12]
         10'h008:
         begin
            nextTxByte = result[7:0];
            nextTxLast = !withData;
         end
         default:
         begin
            if (txPos < T_CNT)
               nextTxByte = setVal; // [R13]
            else if (txPos == T_CNT)
            begin
               nextTxByte = codeCnt; // [R14]
               nextTxLast = (codeCnt == 8'h00);
            end
            else
            begin
               nextTxByte = PROP_BASE + {{(8-IW){1'b0}}, nthSet(flagSnap, k)}; // [R14]
               nextTxLast = (k == codeCnt - 8'h01);
            end
         end
      endcase
   end

   bpna_fifo #(
      .W(9),
      .DEPTH(FIFO_DEPTH)
   ) uFifo (
      .mclk(mclk),
      .rstn(rstn),
      .inData({nextTxLast, nextTxByte}),
      .inValid(state == S_TX),
      .inReady(fifoInReady),
      .outData({txLast, txData}),
      .outValid(txValid),
      .outReady(txReady)
   );

   // Register port and getter readout for the network side
   always @(posedge mclk)
   begin
      if (!rstn)
      begin
         ctrlEn <= `BPNA_CTRL_RESET;
         objReg <= `BPNA_OBJ_RESET;
         regRdata <= 32'h00000000;
         extGetVal <= 8'h00;
      end
      else
      begin
         extGetVal <= getVal;
         regRdata <= 32'h00000000;
         if (regWr)
         begin
            if (regAddr == `BPNA_REG_CTRL)
               ctrlEn <= regWdata[`BPNA_CTRL_EN_BIT];
            else if (regAddr == `BPNA_REG_OBJ)
               objReg <= regWdata[23:0];
         end
         if (regRd)
         begin
            if (regAddr == `BPNA_REG_CTRL)
               regRdata <= {31'h00000000, ctrlEn};
            else if (regAddr == `BPNA_REG_OBJ)
               regRdata <= {8'h00, objReg};
            else if (regAddr == `BPNA_REG_STAT)
               regRdata <= {served, 4'h0, state, popCount(flags), 2'b00};
         end
      end
   end
endmodule

/* File: verification/bpna_bulk_access_sva.sv */
// Checker of the bulk command response stream
`timescale 1ns/1ps
module bpna_bulk_access_sva (
   input wire mclk,
   input wire rstn,
   input wire rxValid,
   input wire rxReady,
   input wire [7:0] txData,
   input wire txValid,
   input wire txLast,
   input wire txReady,
   input wire [2:0] adapterState,
   input wire announceValid
);
   reg [4:0] idx;
   reg [7:0] cmd;
   reg [7:0] lenLo;
   reg [7:0] resHi;
   wire [15:0] res = {resHi, txData};
   wire at8 = txValid && idx == 5'h08;
   wire badSt = adapterState == 3'h1 || adapterState >= 3'h3 && adapterState <= 3'h5;
   // Octet position within the response frame
   always @(posedge mclk)
      if (!rstn)
         idx <= 5'h00;
      else if (txValid && txReady)
      begin
         idx <= txLast ? 5'h00 : idx + 5'h01;
         if (idx == 5'h03)
            cmd <= txData;
         if (idx == 5'h06)
            lenLo <= txData;
         if (idx == 5'h07)
            resHi <= txData;
      end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   property p_start; txValid && idx == 5'h00 |-> txData == 8'h02; endproperty
   a_start: assert property (p_start) else $error("bad start octet");
   property p_cmd; txValid && idx == 5'h03 |-> txData == 8'ha2 || txData == 8'ha3; endproperty
   a_cmd: assert property (p_cmd) else $error("bad response command");
   property p_nlen; txValid && txLast && cmd == 8'ha2 |-> idx == 5'h08; endproperty
   a_nlen: assert property (p_nlen) else $error("notify response length");
   property p_len; txValid && txLast |-> {3'h0, idx} == lenLo + 8'h06; endproperty
   a_len: assert property (p_len) else $error("length field mismatch");
   property p_result;
      at8 |-> res == 16'h0000 || res == 16'h0011 || res == 16'hffff || badSt
         || (cmd == 8'ha2 ? res == 16'h0012 : res == 16'h0001);
   endproperty
   a_result: assert property (p_result) else $error("illegal result");
   property p_state; at8 && badSt |-> res == {8'h01, 5'h00, adapterState}; endproperty
   a_state: assert property (p_state) else $error("state result wrong");
   property p_short; at8 && res > 16'h0001 |-> txLast; endproperty
   a_short: assert property (p_short) else $error("data after reject");
   property p_hold; txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast);
   endproperty
   a_hold: assert property (p_hold) else $error("tx octet dropped");
   property p_busy; !rxReady |-> ##[1:600] rxReady; endproperty
   a_busy: assert property (p_busy) else $error("response never done");
   property p_ann; announceValid |-> $past(rxValid && rxReady); endproperty
   a_ann: assert property (p_ann) else $error("announce without code");
   c_notify: cover property (txValid && idx == 5'h03 && txData == 8'ha2);
   c_values: cover property (txValid && txLast && idx > 5'h08);
   c_stall: cover property (txValid && !txReady);
endmodule
bind bpna_bulk_access bpna_bulk_access_sva chk_u (.mclk, .rstn, .rxValid, .rxReady, .txData,
   .txValid, .txLast, .txReady, .adapterState, .announceValid);

/* File: verification/bpna_ctrl_model.sv */
// Appliance controller model: sends requests and collects responses
`timescale 1ns/1ps
module bpna_ctrl_model (
   input wire mclk,
   output wire [7:0] rxData,
   output reg rxValid = 1'b0,
   output reg rxLast = 1'b0,
   input wire rxReady,
   input wire [7:0] txData,
   input wire txValid,
   input wire txLast,
   output reg txReady = 1'b0,
   input wire [1:0] mode
);
   reg [7:0] reqBuf [0:31];
   reg [7:0] rsp [0:31];
   reg [7:0] cur = 8'h00;
   reg [1:0] tick = 2'h0;
   integer pos = 0;
   integer lastLen = 0;
   integer nFrames = 0;
   // Released data line shows a changing pattern
   assign rxData = rxValid ? cur : ~cur ^ {6'h00, tick};
   task sendFrame(input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1)
         begin
            cur <= reqBuf[i];
            rxValid <= 1'b1;
            rxLast <= i == n - 1;
            @(posedge mclk);
            while (!rxReady)
               @(posedge mclk);
         end
         rxValid <= 1'b0;
         rxLast <= 1'b0;
      end
   endtask
   // Mode 0 prompt, 1 one beat in four, 2 stalled
   always @(posedge mclk)
   begin
      tick <= tick + 2'h1;
      txReady <= mode == 2'h0 || mode == 2'h1 && tick == 2'h0;
   end
   always @(posedge mclk)
      if (txValid && txReady)
      begin
         rsp[pos] <= txData;
         pos <= txLast ? 0 : pos + 1;
         if (txLast)
         begin
            lastLen <= pos + 1;
            nFrames <= nFrames + 1;
         end
      end
endmodule

/* File: verification/bpna_bulk_access_bench.sv */
// Bench of the bulk notify and bulk object access handler
`timescale 1ns/1ps
module bpna_bulk_access_bench;
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] op;
      logic [2:0] st;
      logic [1:0] nt;
      logic [15:0] res;
   } bpna_row_t;
   // Command, code, state, {netUp, object match}, result
   bpna_row_t rows [17] = '{
      {8'h22,8'h00,3'h0,2'h3,16'h0000}, {8'h22,8'h01,3'h0,2'h3,16'h0000},
      {8'h22,8'h02,3'h0,2'h3,16'h0000}, {8'h22,8'h03,3'h0,2'h3,16'h0000},
      {8'h22,8'h04,3'h0,2'h3,16'hffff}, {8'h22,8'h00,3'h0,2'h1,16'h0011},
      {8'h22,8'h01,3'h0,2'h2,16'h0012}, {8'h22,8'h00,3'h1,2'h3,16'h0101},
      {8'h22,8'h00,3'h3,2'h3,16'h0103}, {8'h23,8'h00,3'h4,2'h3,16'h0104},
      {8'h23,8'h00,3'h5,2'h3,16'h0105}, {8'h23,8'h01,3'h0,2'h3,16'h0000},
      {8'h23,8'h00,3'h0,2'h3,16'h0000}, {8'h23,8'h00,3'h0,2'h1,16'h0001},
      {8'h23,8'h02,3'h0,2'h3,16'hffff}, {8'h23,8'h00,3'h0,2'h2,16'h0011},
      {8'h22,8'h00,3'h2,2'h3,16'hffff}};
   reg mclk = 1'b0, rstn = 1'b0, netUp = 1'b1;
   reg [2:0] adapterState = 3'h0;
   reg extWr = 1'b0;
   reg [2:0] extIdx = 3'h0;
   reg [7:0] extData = 8'h00;
   reg [3:0] regAddr = 4'h0;
   reg [31:0] regWdata = 32'h0;
   reg regWr = 1'b0, regRd = 1'b0;
   reg [1:0] mode = 2'h0;
   wire [7:0] rxData, txData, extGetVal, announceCode;
   wire rxValid, rxLast, rxReady, txValid, txLast, txReady, announceValid;
   wire [31:0] regRdata;
   integer errTotal = 0, checked = 0, annCnt = 0, r, n0;
   reg [31:0] rd;
   reg [87:0] hdr;
   reg [7:0] marks = 8'h00;
   reg [7:0] expGet [0:7], expSet [0:7], e [0:31];
   always #25 mclk = ~mclk;
   bpna_bulk_access #(.N(8), .PROP_BASE(8'h80), .FIFO_DEPTH(16)) dut_u (.*);
   bpna_ctrl_model model_u (.*);
   // Every accepted notify announces codes 81 then 84
   always @(posedge mclk)
      if (announceValid)
      begin
         annCnt <= annCnt + 1;
         check("ann code", announceCode, annCnt[0] ? 8'h84 : 8'h81);
      end
   task check(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp)
         begin
            errTotal = errTotal + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task summarize;
      begin
         if (errTotal == 0 && checked > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task regWrite(input [3:0] a, input [31:0] d);
      begin
         regAddr <= a;
         regWdata <= d;
         regWr <= 1'b1;
         @(posedge mclk);
         regWr <= 1'b0;
         @(posedge mclk);
      end
   endtask
   task regRead(input [3:0] a);
      begin
         regAddr <= a;
         regRd <= 1'b1;
         @(posedge mclk);
         regRd <= 1'b0;
         #1 rd = regRdata;
         @(posedge mclk);
      end
   endtask
   task extWrite(input [2:0] i, input [7:0] d);
      begin
         extIdx <= i;
         extData <= d;
         extWr <= 1'b1;
         @(posedge mclk);
         extWr <= 1'b0;
         @(posedge mclk);
         expSet[i] = d;
         marks[i] = 1'b1;
      end
   endtask
   task sendReq(input [7:0] cmd, input [7:0] op, input objOk, input [3:0] t);
      integer i, n;
      begin
         n = (cmd == 8'h22) ? 22 : (op == 8'h01) ? 19 : 11;
         hdr = {8'h02, 16'h0003, cmd, 4'h4, t, 16'(n - 7), op, 16'h0012,
            objOk ? 8'hab : 8'hac};
         for (i = 0; i < 22; i = i + 1)
            model_u.reqBuf[i] = i < 11 ? hdr[87 - 8 * i -: 8] : i < 19 ? {t, 4'(i - 11)}
               : i == 19 ? 8'h02 : i == 20 ? 8'h81 : 8'h84;
         model_u.sendFrame(n);
      end
   endtask
   task runRow(input bpna_row_t w, input [3:0] t);
      integer i, n, k, a0;
      begin
         adapterState <= w.st;
         netUp <= w.nt[1];
         n0 = model_u.nFrames;
         a0 = annCnt;
         sendReq(w.cmd, w.op, w.nt[0], t);
         for (k = 0; k < 2000 && model_u.nFrames == n0; k = k + 1)
            @(posedge mclk);
         check("answered", model_u.nFrames, n0 + 1);
         n = 9;
         if (w.cmd == 8'h23 && w.op == 8'h00 && w.res <= 16'h0001)
         begin
            n = 18;
            for (i = 0; i < 8; i = i + 1)
            begin
               e[9 + i] = expSet[i];
               e[n] = {5'h10, i[2:0]};
               n = n + marks[i];
            end
            e[17] = 8'(n - 18);
            marks = 8'h00;
         end
         hdr = {8'h02, 16'h0003, w.cmd | 8'h80, 4'h4, t, 16'(n - 7), w.res, 16'h0000};
         for (i = 0; i < 9; i = i + 1)
            e[i] = hdr[87 - 8 * i -: 8];
         check("length", model_u.lastLen, n);
         for (i = 0; i < n; i = i + 1)
            check("octet", model_u.rsp[i], e[i]);
         check("announces", annCnt - a0, w.cmd == 8'h22 && w.res == 16'h0 ? 2 : 0);
         for (i = 0; i < 8; i = i + 1)
            if (w.res == 16'h0 && w.cmd == 8'h22 && w.op == 8'h01)
               expSet[i] = {t, i[3:0]};
            else if (w.res == 16'h0 && w.op == w.cmd - 8'h22)
               expGet[i] = {t, i[3:0]};
      end
   endtask
   initial
   begin
      repeat (15) @(posedge mclk);
      check("rst rxReady", rxReady, 1);
      check("rst txValid", txValid, 0);
      @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      regRead(4'h0);
      check("ctrl rst", rd, 1);
      regRead(4'h4);
      check("obj rst", rd, 0);
      regWrite(4'h4, 32'h0012ab);
      regWrite(4'hc, 32'hffffffff);
      regRead(4'h4);
      check("obj", rd, 32'h0012ab);
      regRead(4'hc);
      check("unmapped", rd, 0);
      extWrite(3'h5, 8'h5e);
      extWrite(3'h2, 8'h2e);
      for (r = 0; r < 17; r = r + 1)
      begin
         mode <= r[0] ? 2'h1 : 2'h0;
         runRow(rows[r], r[3:0]);
      end
      adapterState <= 3'h0;
      netUp <= 1'b1;
      for (r = 0; r < 8; r = r + 1)
      begin
         extIdx <= r[2:0];
         repeat (2) @(posedge mclk);
         check("getter", extGetVal, expGet[r]);
      end
      extWrite(3'h7, 8'h77);
      mode <= 2'h2;
      fork
         runRow(rows[12], 4'h9);
         begin
            repeat (60) @(posedge mclk);
            check("fifo full", rxReady, 0);
            mode <= 2'h0;
         end
      join
      regWrite(4'h0, 32'h0);
      n0 = model_u.nFrames;
      r = annCnt;
      sendReq(8'h22, 8'h00, 1'b1, 4'h3);
      repeat (50) @(posedge mclk);
      check("disabled", model_u.nFrames, n0);
      check("disabled ann", annCnt, r);
      regWrite(4'h0, 32'h1);
      runRow(rows[0], 4'h5);
      summarize;
   end
   initial
   begin
      repeat (20000) @(posedge mclk);
      errTotal = errTotal + 1;
      summarize;
   end
endmodule
